/* File: design/flr_device.sv */
/*
  readback device: arms fuse/lock, signature and store operations from
  control writes, answers loads from fuses, lock bits, signature row or
  flash, and times flash writes.
  assumes the flash array answers flash_rdata combinationally from
  flash_addr, and porn is a power-on reset separate from resetn.
*/
// Local design decisions: register access over Avalon-MM and the register offsets.
`default_nettype none
module flr_device
  import flr_pkg::*;
#(
  parameter int FLASH_WRITE_CYCLES = FLASH_WR_MIN_CYC // write duration in cycles
) (
  // clock and resets
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        porn,
  // cpu link
  flr_if.dev               link,
  // flash array
  output logic      [15:0] flash_addr,
  input  wire logic [7:0]  flash_rdata,
  // write engine status
  output logic             write_busy
);

  // arming and load pipeline, under system reset
  typedef struct packed {
    flr_mode_t   mode;    // armed operation
    logic [2:0]  win;     // cycles since the arming write
    logic        ld_pend; // load waiting for its answer
    flr_src_t    ld_src;  // where the answer comes from
    logic [7:0]  ld_spec; // fuse, lock or signature byte
    logic [15:0] fl_addr; // flash address of the load
    logic        ld_vld;  // answer strobe
    logic [7:0]  ld_data; // answer byte
  } flr_dev_t;

  // write engine, under power-on reset only
  typedef struct packed {
    logic             busy;      // write running
    logic [TMR_W-1:0] tmr;       // cycles left
    logic             lock_pend; // write is a lock write
    logic [7:0]       lock_data; // lock value to merge
    logic [7:0]       lock;      // stored lock bits
  } flr_wr_t;

  flr_dev_t s, next_s;  // arming state
  flr_wr_t  w, next_w;  // write engine state
  logic     start_wr;   // a write starts this cycle
  logic     start_lock; // and it is a lock write

  // fuse or lock byte at the pointer; stored bits are already 0 = programmed
  function automatic logic [7:0] fuse_lookup(input logic [15:0] p, input logic [7:0] lk);
    logic [7:0] v;
    v = 8'hff;
    case (p)
      PTR_FUSE_LOW:  v = FUSE_LOW_VAL;
      PTR_LOCK:      v = lk;
      PTR_FUSE_EXT:  v = FUSE_EXT_VAL;
      PTR_FUSE_HIGH: v = FUSE_HIGH_VAL;
      default:       v = 8'hff;
    endcase
    return v;
  endfunction : fuse_lookup

  // signature row byte at the pointer; reserved addresses give all ones
  function automatic logic [7:0] sig_lookup(input logic [15:0] p);
    logic [7:0] v;
    v = 8'hff;
    case (p)
      PTR_SIG1: v = SIG1_VAL;
      PTR_SIG2: v = SIG2_VAL;
      PTR_SIG3: v = SIG3_VAL;
      PTR_CAL:  v = CAL_VAL;
      default:  v = 8'hff;
    endcase
    return v;
  endfunction : sig_lookup

  // arming, windows and the two-stage load path
  always_comb begin
    next_s        = s;
    next_s.ld_vld = 1'b0;
    start_wr      = 1'b0;
    start_lock    = 1'b0;

    // every load answers in the second stage
    if (s.ld_pend) begin
      next_s.ld_pend = 1'b0;
      next_s.ld_vld  = 1'b1;
      next_s.ld_data = (s.ld_src == FLR_SRC_FLASH) ? flash_rdata : s.ld_spec;
    end

    // window age, counted from the cycle after the write
    if (s.mode != FLR_IDLE && s.win != STORE_WIN) begin
      next_s.win = s.win + 3'h1;
    end

    // ordinary load unless an armed read takes it below
    if (link.lpm_req) begin
      next_s.ld_pend = 1'b1;
      next_s.ld_src  = FLR_SRC_FLASH;
      next_s.fl_addr = link.ptr;
    end

    case (s.mode)
      FLR_IDLE: begin
        // nothing armed
      end
      FLR_ARM_FUSE: begin
        if (link.lpm_req && s.win < LOAD_WIN) begin
          // armed fuse/lock read; polarity kept by storage
          next_s.ld_src  = FLR_SRC_SPEC;
          next_s.ld_spec = fuse_lookup(link.ptr, w.lock);
          next_s.mode    = FLR_IDLE;
        end else if (link.spm_req && s.win < STORE_WIN && !w.busy) begin
          // lock write from the store data
          start_wr    = 1'b1;
          start_lock  = 1'b1;
          next_s.mode = FLR_IDLE;
        end else if (s.win == STORE_WIN - 3'h1) begin
          // neither load nor store came in time
          next_s.mode = FLR_IDLE;
        end
      end
      FLR_ARM_SIG: begin
        if (link.lpm_req && s.win < LOAD_WIN) begin
          next_s.ld_src  = FLR_SRC_SPEC;
          next_s.ld_spec = sig_lookup(link.ptr);
          next_s.mode    = FLR_IDLE;
        end else if (s.win == LOAD_WIN - 3'h1) begin
          next_s.mode = FLR_IDLE;
        end
      end
      FLR_ARM_SPM: begin
        if (link.spm_req && s.win < STORE_WIN && !w.busy) begin
          // page erase or page write; its decoding lies elsewhere
          start_wr    = 1'b1;
          next_s.mode = FLR_IDLE;
        end else if (s.win == STORE_WIN - 3'h1) begin
          next_s.mode = FLR_IDLE;
        end
      end
      default: begin
        next_s.mode = FLR_IDLE;
      end
    endcase

    // a control write re-arms; ignored while a write runs
    if (link.ctrl_we && !w.busy) begin
      next_s.win = 3'h0;
      if (!link.ctrl_wdata[CTRL_SPE_BIT]) begin
        next_s.mode = FLR_IDLE;
      end else if (link.ctrl_wdata[CTRL_FLRS_BIT]) begin
        next_s.mode = FLR_ARM_FUSE;
      end else if (link.ctrl_wdata[CTRL_SIGNATURE_READ_SELECT_BIT]) begin
        next_s.mode = FLR_ARM_SIG;
      end else begin
        next_s.mode = FLR_ARM_SPM;
      end
    end
  end

  // write timer; the clock is derived from the calibrated oscillator
  always_comb begin
    next_w = w;
    if (w.busy) begin
      if (w.tmr == '0) begin
        next_w.busy = 1'b0;
        // lock bits below the top two are programmed where the data holds zero
        if (w.lock_pend) begin
          next_w.lock = w.lock & (w.lock_data | LOCK_KEEP);
        end
        next_w.lock_pend = 1'b0;
      end else begin
        next_w.tmr = w.tmr - {{(TMR_W-1){1'b0}}, 1'b1};
      end
    end else if (start_wr) begin
      // fixed duration inside the documented range
      next_w.busy      = 1'b1;
      next_w.tmr       = TMR_W'(FLASH_WRITE_CYCLES - 1);
      next_w.lock_pend = start_lock;
      next_w.lock_data = link.spm_data;
    end
  end

  // arming state registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '{mode: FLR_IDLE, ld_src: FLR_SRC_FLASH, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // system reset does not stop a running write
  always_ff @(posedge clk_sys or negedge porn) begin
    if (!porn) begin
      w <= '{lock: LOCK_RST, default: '0};
    end else begin
      w <= next_w;
    end
  end

  // link outputs; control read shows armed bits and write status
  assign link.lpm_valid  = s.ld_vld;
  assign link.lpm_data   = s.ld_data;
  assign link.busy       = w.busy;
  assign link.ctrl_rdata = {1'b0, w.busy, s.mode == FLR_ARM_SIG, 1'b0,
                            s.mode == FLR_ARM_FUSE, 2'b00, s.mode != FLR_IDLE};
  assign flash_addr      = s.fl_addr;
  assign write_busy      = w.busy;

endmodule : flr_device
`default_nettype wire

/* File: design/flr_pkg.sv */
/*
  shared constants for the fuse, lock and signature readback block:
  control layout, pointer codes, stored byte values, timing and the
  software register map of the cpu-side end.
  assumes a single 50 MHz clock shared by both ends.
*/
`default_nettype none
package flr_pkg;
  // clock period of clk_sys
  localparam int CLK_PERIOD_NS   = 20;
  // flash write duration, least and longest
  localparam int FLASH_WR_MIN_NS = 3_700_000;
  localparam int FLASH_WR_MAX_NS = 4_500_000;
  localparam int FLASH_WR_MIN_CYC = (FLASH_WR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLASH_WR_MAX_CYC = FLASH_WR_MAX_NS / CLK_PERIOD_NS;
  localparam int TMR_W            = 18;

  // windows after the control write, in cycles
  localparam logic [2:0] LOAD_WIN  = 3'h3;
  localparam logic [2:0] STORE_WIN = 3'h4;

  // control register bit positions
  localparam int CTRL_SPE_BIT   = 0; // self/store program enable
  localparam int CTRL_FLRS_BIT  = 3; // fuse/lock read select
  localparam int CTRL_SIGNATURE_READ_SELECT_BIT = 5; // signature read select
  localparam int CTRL_BUSY_BIT  = 6; // flash write running

  // pointer codes for fuse/lock reads
  localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] PTR_LOCK      = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT  = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
  // pointer codes for signature reads
  localparam logic [15:0] PTR_SIG1 = 16'h0000;
  localparam logic [15:0] PTR_CAL  = 16'h0001;
  localparam logic [15:0] PTR_SIG2 = 16'h0002;
  localparam logic [15:0] PTR_SIG3 = 16'h0004;

  // stored bytes, 1 = unprogrammed; fuse values are arbitrary but distinct,
  // so a swapped pointer decode cannot hide behind equal bytes
  localparam logic [7:0] FUSE_LOW_VAL  = 8'h62;
  localparam logic [7:0] FUSE_HIGH_VAL = 8'hd9;
  localparam logic [7:0] FUSE_EXT_VAL  = 8'hfd;
  localparam logic [7:0] LOCK_RST      = 8'hff;
  localparam logic [7:0] CAL_VAL       = 8'h80;
  // identification bytes: values are arbitrary
  localparam logic [7:0] SIG1_VAL = 8'h5a;
  localparam logic [7:0] SIG2_VAL = 8'h3c;
  localparam logic [7:0] SIG3_VAL = 8'h96;
  // lock write keeps the top two bits
  localparam logic [7:0] LOCK_KEEP = 8'hc0;

  // software register map of the cpu-side end (byte addresses)
  localparam logic [3:0] REG_PTR    = 4'h0;
  localparam logic [3:0] REG_CTRL   = 4'h4;
  localparam logic [3:0] REG_CMD    = 4'h8;
  localparam logic [3:0] REG_RESULT = 4'hc;
  localparam int CMD_LOAD_BIT   = 0;
  localparam int CMD_STORE_BIT  = 1;
  localparam int CMD_DATA_LSB   = 8;
  localparam int RES_VALID_BIT  = 8;
  localparam int RES_BUSY_BIT   = 9;

  // arming mode of the device
  typedef enum logic [1:0] {
    FLR_IDLE     = 2'b00,
    FLR_ARM_FUSE = 2'b01,
    FLR_ARM_SIG  = 2'b10,
    FLR_ARM_SPM  = 2'b11
  } flr_mode_t;

  // source of a pending load
  typedef enum logic [0:0] {
    FLR_SRC_FLASH = 1'b0,
    FLR_SRC_SPEC  = 1'b1
  } flr_src_t;
endpackage : flr_pkg
`default_nettype wire

/* File: design/flr_if.sv */
/*
  link between the cpu end and the readback device: control writes,
  pointer, load and store strobes, load answers.
  assumes both ends run on the same clk_sys; no clocking here.
*/
`default_nettype none
interface flr_if;
  logic        ctrl_we;    // control write strobe
  logic [7:0]  ctrl_wdata; // control write value
  logic [7:0]  ctrl_rdata; // control read back
  logic [15:0] ptr;        // pointer register pair
  logic        lpm_req;    // program-memory load strobe
  logic        spm_req;    // store-program strobe
  logic [7:0]  spm_data;   // store data byte
  logic        lpm_valid;  // load answer strobe
  logic [7:0]  lpm_data;   // load answer byte
  logic        busy;       // flash write running

  // documented device end
  modport dev (
    input  ctrl_we, ctrl_wdata, ptr, lpm_req, spm_req, spm_data,
    output ctrl_rdata, lpm_valid, lpm_data, busy
  );
  // cpu end
  modport cpu (
    output ctrl_we, ctrl_wdata, ptr, lpm_req, spm_req, spm_data,
    input  ctrl_rdata, lpm_valid, lpm_data, busy
  );
endinterface : flr_if
`default_nettype wire

/* File: design/flr_host.sv */
/*
  cpu-side end: software reaches pointer, control, command and result
  registers over avalon-mm and this end drives the link strobes.
  assumes the device end shares clk_sys; the bus master holds each
  request until waitrequest is low.
*/
`default_nettype none
module flr_host
  import flr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // link to device
  flr_if.cpu               link
);

  // whole state of this end
  typedef struct packed {
    logic        ack;        // second bus cycle, answer now
    logic [31:0] rdata;      // read answer
    logic [15:0] ptr;        // pointer register
    logic        ctrl_we;    // control write strobe
    logic [7:0]  ctrl_wdata; // control value
    logic        lpm_req;    // load strobe
    logic        spm_req;    // store strobe
    logic [7:0]  spm_data;   // store data
    logic [7:0]  res_data;   // last load answer
    logic        res_valid;  // answer not yet read
  } flr_host_t;

  flr_host_t h, next_h; // state and next state
  logic      req;       // a bus request is present

  // register read decode, unmapped reads give zero
  function automatic logic [31:0] reg_read(input logic [3:0] a, input flr_host_t st,
                                           input logic [7:0] crd, input logic bsy);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      REG_PTR:    v = {16'h0000, st.ptr};
      REG_CTRL:   v = {24'h00_0000, crd};
      REG_RESULT: begin
        v[7:0]          = st.res_data;
        v[RES_VALID_BIT] = st.res_valid;
        v[RES_BUSY_BIT]  = bsy;
      end
      default:    v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_read

  assign req = read | write;

  // bus access and link strobes
  always_comb begin
    next_h         = h;
    next_h.ctrl_we = 1'b0;
    next_h.lpm_req = 1'b0;
    next_h.spm_req = 1'b0;
    next_h.ack     = req && !h.ack;
    // first cycle: prepare read answer
    if (read && !h.ack) begin
      next_h.rdata = reg_read(address, h, link.ctrl_rdata, link.busy);
    end
    // answer edge: only a read that returned the flag set drops it, so an
    // answer landing while the read is in flight is not lost
    if (read && h.ack && address == REG_RESULT && h.rdata[RES_VALID_BIT]) begin
      next_h.res_valid = 1'b0;
    end
    // answer edge: writes take effect
    if (write && h.ack) begin
      case (address)
        REG_PTR: begin
          if (byteenable[0]) next_h.ptr[7:0] = writedata[7:0];
          if (byteenable[1]) next_h.ptr[15:8] = writedata[15:8];
        end
        REG_CTRL: begin
          if (byteenable[0]) begin
            next_h.ctrl_we    = 1'b1;
            next_h.ctrl_wdata = writedata[7:0];
          end
        end
        REG_CMD: begin
          // load goes out one cycle after the write
          if (byteenable[0]) begin
            next_h.lpm_req = writedata[CMD_LOAD_BIT];
            next_h.spm_req = writedata[CMD_STORE_BIT] & ~writedata[CMD_LOAD_BIT];
          end
          if (byteenable[1]) begin
            next_h.spm_data = writedata[CMD_DATA_LSB +: 8];
          end
        end
        default: begin
          // unmapped write is dropped
        end
      endcase
    end
    // a new answer wins over a clear in the same cycle
    if (link.lpm_valid) begin
      next_h.res_data  = link.lpm_data;
      next_h.res_valid = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      h <= '0;
    end else begin
      h <= next_h;
    end
  end

  // outputs
  assign waitrequest     = req && !h.ack;
  assign readdata        = h.rdata;
  assign link.ptr        = h.ptr;
  assign link.ctrl_we    = h.ctrl_we;
  assign link.ctrl_wdata = h.ctrl_wdata;
  assign link.lpm_req    = h.lpm_req;
  assign link.spm_req    = h.spm_req;
  assign link.spm_data   = h.spm_data;

endmodule : flr_host
`default_nettype wire

/* File: dv/flr_monitor.sv */
/*
  checker for the readback link: watches the link signals only.
  assumes one clock, resetn active low, busy counted in clk_sys cycles.
*/
`default_nettype none
module flr_monitor
  import flr_pkg::*;
#(
  parameter int FLASH_WRITE_CYCLES = FLASH_WR_MIN_CYC // write length in cycles
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // link signals
  input wire logic        ctrl_we,
  input wire logic [7:0]  ctrl_wdata,
  input wire logic [7:0]  ctrl_rdata,
  input wire logic [15:0] ptr,
  input wire logic        lpm_req,
  input wire logic        spm_req,
  input wire logic        lpm_valid,
  input wire logic [7:0]  lpm_data,
  input wire logic        busy
);
  logic [2:0]  since; // edges since the accepted control write
  logic        used;  // arming already consumed
  logic [7:0]  wd;    // last accepted control value
  logic [31:0] bcnt;  // busy cycles so far
  logic        fok;   // armed fuse/lock load would be honoured
  logic        sok;   // armed signature load would be honoured
  assign fok = since inside {[3'h1:3'h3]} && !used && wd[CTRL_FLRS_BIT] && wd[CTRL_SPE_BIT];
  assign sok = since inside {[3'h1:3'h3]} && !used && !wd[CTRL_FLRS_BIT] && wd[CTRL_SIGNATURE_READ_SELECT_BIT] && wd[CTRL_SPE_BIT];
  // window tracking; a control write while busy is dropped by the device
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      since <= 3'h7;
      used  <= 1'b1;
      wd    <= 8'h00;
    end else if (ctrl_we && !busy) begin
      since <= 3'h1;
      used  <= 1'b0;
      wd    <= ctrl_wdata;
    end else begin
      since <= (since == 3'h7) ? since : since + 3'h1;
      used  <= used || lpm_req || spm_req;
    end
  end
  // no reset here: a system reset must not cut a write short
  always_ff @(posedge clk_sys) begin
    bcnt <= busy ? bcnt + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  chk_load_latency: assert property (lpm_req |-> ##2 lpm_valid)
    else $error("load answer not two cycles after request");
  chk_valid_cause: assert property (lpm_valid |-> $past(lpm_req, 2))
    else $error("load answer without request");
  chk_data_stands: assert property (!lpm_valid |-> $stable(lpm_data))
    else $error("load data moved without answer");
  chk_fuse_low: assert property (fok && lpm_req && ptr == PTR_FUSE_LOW |-> ##2 lpm_data == FUSE_LOW_VAL)
    else $error("fuse low byte wrong");
  chk_fuse_high: assert property (fok && lpm_req && ptr == PTR_FUSE_HIGH |-> ##2 lpm_data == FUSE_HIGH_VAL)
    else $error("fuse high byte wrong");
  chk_sig_first: assert property (sok && lpm_req && ptr == PTR_SIG1 |-> ##2 lpm_data == SIG1_VAL)
    else $error("first id byte wrong");
  chk_sig_cal: assert property (sok && lpm_req && ptr == PTR_CAL |-> ##2 lpm_data == CAL_VAL)
    else $error("calibration byte wrong");
  chk_fuse_clear: assert property (ctrl_we && !busy ##1 !ctrl_we [*4] |=> !ctrl_rdata[CTRL_FLRS_BIT])
    else $error("fuse arming outlived its window");
  chk_sig_clear: assert property (ctrl_we && !busy ##1 !ctrl_we [*3] |=> !ctrl_rdata[CTRL_SIGNATURE_READ_SELECT_BIT])
    else $error("signature arming outlived its window");
  chk_clear_on_read: assert property (lpm_req && !ctrl_we && (fok || sok) |=> (ctrl_rdata & 8'h29) == 8'h00)
    else $error("arming kept after read");
  chk_busy_start: assert property (spm_req && !busy && fok |=> busy)
    else $error("store did not start a write");
  chk_busy_len: assert property ($fell(busy) |-> bcnt == FLASH_WRITE_CYCLES)
    else $error("write length wrong");
endmodule : flr_monitor
`default_nettype wire

/* File: dv/fuse_lock_signature_readback_tb.sv */
/*
  bench: host and device joined by the link, an avalon master, a flash
  array model and one task per scenario.
  assumes flr_pkg, flr_if, both ends and the checker are compiled first.
*/
`default_nettype none
module fuse_lock_signature_readback_tb
  import flr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WCYC = 20; // shortened write length
  logic        clk_sys      = 1'b0;
  logic        resetn       = 1'b0;
  logic        porn         = 1'b0;
  logic [3:0]  address      = 4'h0;
  logic        read         = 1'b0;
  logic        write        = 1'b0;
  logic [31:0] writedata    = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [15:0] flash_addr;
  logic [7:0]  flash_rdata;
  logic        write_busy;
  int          mismatches   = 0;
  int          total_checks = 0;
  // flash model: bytes unlike any special value at low addresses
  function automatic logic [7:0] fbyte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'he7;
  endfunction : fbyte
  assign flash_rdata = fbyte(flash_addr);
  flr_if flr_link ();
  flr_host flr_host_i (.clk_sys(clk_sys), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest), .link(flr_link.cpu));
  flr_device #(.FLASH_WRITE_CYCLES(WCYC)) flr_device_i (.clk_sys(clk_sys), .resetn(resetn), .porn(porn),
    .link(flr_link.dev), .flash_addr(flash_addr), .flash_rdata(flash_rdata), .write_busy(write_busy));
  flr_monitor #(.FLASH_WRITE_CYCLES(WCYC)) flr_monitor_i (.clk_sys(clk_sys), .resetn(resetn),
    .ctrl_we(flr_link.ctrl_we), .ctrl_wdata(flr_link.ctrl_wdata), .ctrl_rdata(flr_link.ctrl_rdata),
    .ptr(flr_link.ptr), .lpm_req(flr_link.lpm_req), .spm_req(flr_link.spm_req),
    .lpm_valid(flr_link.lpm_valid), .lpm_data(flr_link.lpm_data), .busy(flr_link.busy));
  // 50 MHz
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    total_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check
  // one access, held until waitrequest is sampled low; no release, so calls chain
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    q = readdata;
    check(32'(n < 20), 32'h1, "bus answer");
  endtask : bus
  task automatic idle();
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);
  endtask : idle
  // pointer, optional arming, g idle cycles, load command, then poll the result
  task automatic load(input logic [15:0] p, input logic [7:0] c, input int g, output logic [31:0] q);
    bus(1'b1, REG_PTR, {16'h0, p}, q);
    if (c != 8'h00) bus(1'b1, REG_CTRL, {24'h0, c}, q);
    repeat (g) idle();
    bus(1'b1, REG_CMD, 32'h1, q);
    q = 32'h0;
    repeat (8) begin
      if (!q[RES_VALID_BIT]) bus(1'b0, REG_RESULT, 32'h0, q);
    end
    idle();
    check({31'h0, q[RES_VALID_BIT]}, 32'h1, "load answered");
  endtask : load
  task automatic t_fuse();
    logic [31:0] q;
    logic [7:0]  want [4];
    want = '{FUSE_LOW_VAL, LOCK_RST, FUSE_EXT_VAL, FUSE_HIGH_VAL};
    for (int i = 0; i < 4; i++) begin
      load(16'(i), 8'h09, 0, q);
      check({24'h0, q[7:0]}, {24'h0, want[i]}, "fuse byte");
      bus(1'b0, REG_CTRL, 32'h0, q);
      idle();
      check(q & 32'h29, 32'h0, "fuse arming left");
    end
  endtask : t_fuse
  task automatic t_sig();
    logic [31:0] q;
    logic [15:0] p [5];
    logic [7:0]  want [5];
    // software keeps to four addresses; the fifth only probes the reserved answer
    p    = '{PTR_SIG1, PTR_CAL, PTR_SIG2, PTR_SIG3, 16'h0003};
    want = '{SIG1_VAL, CAL_VAL, SIG2_VAL, SIG3_VAL, 8'hff};
    for (int i = 0; i < 5; i++) begin
      load(p[i], 8'h21, 0, q);
      check({24'h0, q[7:0]}, {24'h0, want[i]}, "signature byte");
      bus(1'b0, REG_CTRL, 32'h0, q);
      idle();
      check(q & 32'h29, 32'h0, "signature arming left");
    end
  endtask : t_sig
  // unarmed loads, one at the lock pointer, read the flash array
  task automatic t_plain();
    logic [31:0] q;
    load(16'h1234, 8'h00, 0, q);
    check({24'h0, q[7:0]}, {24'h0, fbyte(16'h1234)}, "flash byte");
    load(PTR_LOCK, 8'h00, 0, q);
    check({24'h0, q[7:0]}, {24'h0, fbyte(PTR_LOCK)}, "flash at lock pointer");
  endtask : t_plain
  // arm, let the window lapse, then a load must read flash; the third edge still counts
  task automatic t_late();
    logic [31:0] q;
    logic [7:0]  c [2];
    logic [7:0]  arm [2];
    c   = '{8'h09, 8'h21};
    arm = '{LOCK_RST, CAL_VAL};
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, REG_CTRL, {24'h0, c[i]}, q);
      idle();
      repeat (4) @(posedge clk_sys);
      load(PTR_CAL, 8'h00, 0, q);
      check({24'h0, q[7:0]}, {24'h0, fbyte(PTR_CAL)}, "load after window");
      load(PTR_CAL, c[i], 1, q);
      check({24'h0, q[7:0]}, {24'h0, arm[i]}, "load on last window edge");
      load(PTR_CAL, c[i], 2, q);
      check({24'h0, q[7:0]}, {24'h0, fbyte(PTR_CAL)}, "load one edge late");
    end
  endtask : t_late
  // plain store arming starts a write; a control write while it runs is refused
  task automatic t_spm();
    logic [31:0] q;
    bus(1'b1, REG_CTRL, 32'h1, q);
    bus(1'b1, REG_CMD, 32'h2, q);
    bus(1'b1, REG_CTRL, 32'h9, q);
    idle();
    bus(1'b0, REG_CTRL, 32'h0, q);
    idle();
    check(q & 32'h69, 32'h40, "arming refused while busy");
    repeat (2 * WCYC) begin
      if (write_busy === 1'b1) @(posedge clk_sys);
    end
    check({31'h0, write_busy}, 32'h0, "plain write ended");
  endtask : t_spm
  // lock write with a system reset in mid-write, then read the lock byte
  task automatic t_lock();
    logic [31:0] q;
    int          n;
    bus(1'b1, REG_CTRL, 32'h9, q);
    bus(1'b1, REG_CMD, 32'h2, q);
    idle();
    @(posedge clk_sys);
    check({31'h0, write_busy}, 32'h1, "write started");
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    check({31'h0, write_busy}, 32'h1, "write survives reset");
    n = 0;
    while (write_busy === 1'b1 && n < 2 * WCYC) begin
      @(posedge clk_sys);
      n++;
    end
    check(32'(n + 3), WCYC, "write length");
    load(PTR_LOCK, 8'h09, 0, q);
    check({24'h0, q[7:0]}, {24'h0, LOCK_RST & LOCK_KEEP}, "lock after write");
  endtask : t_lock
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    porn   <= 1'b1;
    @(posedge clk_sys);
    t_fuse();
    t_sig();
    t_plain();
    t_late();
    t_lock();
    t_spm();
    test_done();
  end
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end
endmodule : fuse_lock_signature_readback_tb
`default_nettype wire
